/* hw/swdt_pkg.sv */
`default_nettype none
package swdt_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam logic [31:0] OFS_MODE    = 32'hE000_0000;
  localparam logic [31:0] OFS_RELOAD  = 32'hE000_0004;
  localparam logic [31:0] OFS_FEED    = 32'hE000_0008;
  localparam logic [31:0] OFS_COUNT   = 32'hE000_000C;
  localparam logic [31:0] OFS_IRQ_STS = 32'hE000_0010;
  localparam logic [31:0] OFS_IRQ_EN  = 32'hE000_0014;
  localparam logic [31:0] OFS_IRQ_CLR = 32'hE000_0018;

  // ****************************************
  // mode register fields
  // ****************************************
  localparam int MODE_EN_BIT  = 0;
  localparam int MODE_RST_BIT = 1;
  localparam int MODE_TOF_BIT = 2;
  localparam int MODE_INT_BIT = 3;
  localparam int MODE_W       = 4;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [31:0] RELOAD_RST  = 32'h0000_00FF;
  localparam logic [31:0] RELOAD_MIN  = 32'h0000_00FF;
  localparam logic [31:0] COUNT_RST   = 32'h0000_00FF;
  localparam logic [7:0]  FEED_FIRST  = 8'hAA;
  localparam logic [7:0]  FEED_SECOND = 8'h55;
  localparam int          PRESCALE_DIV = 4;

  // ****************************************
  // interrupt events
  // ****************************************
  localparam int          EVT_TIMEOUT  = 0;
  localparam int          EVT_FEED_ERR = 1;
  localparam int          EVT_W        = 2;
  localparam logic [1:0]  IRQ_EN_RST   = 2'h0;

  typedef enum logic [1:0] {
    SWDT_FEED_IDLE = 2'b01,
    SWDT_FEED_HALF = 2'b10
  } swdt_feed_e;
endpackage : swdt_pkg
`default_nettype wire

/* hw/swdt_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
module swdt_prescale #(
  parameter int DIV = swdt_pkg::PRESCALE_DIV
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic run,
  input  wire logic clr,
  output logic      tick
);
  import swdt_pkg::*;

  localparam int             CW   = (DIV < 2) ? 1 : $clog2(DIV);
  localparam logic [CW-1:0]  LAST = CW'(DIV - 1);

  if (DIV < 2) begin : g_bad_div
    $error("swdt_prescale: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // ****************************************
  // divide by DIV phase counter
  // ****************************************
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr || !run || cnt_r == LAST) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = run && !clr && (cnt_r == LAST);

  a_tick_spacing: assert property (
    @(posedge core_clk) disable iff (reset) tick |=> !tick [*3])
    else $error("prescaler ticks closer than four clocks");
endmodule : swdt_prescale
`default_nettype wire

/* hw/swdt_feed_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module swdt_feed_seq (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       acc,
  input  wire logic       feed_wr,
  input  wire logic [7:0] wbyte,
  output logic            feed_ok,
  output logic            feed_err
);
  import swdt_pkg::*;

  swdt_feed_e state_r;
  swdt_feed_e state_nxt;
  logic       ok_nxt;
  logic       err_nxt;

  // ****************************************
  // two byte feed sequence
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    ok_nxt    = 1'b0;
    err_nxt   = 1'b0;
    case (state_r)
      SWDT_FEED_IDLE: begin
        if (acc && feed_wr) begin
          if (wbyte == FEED_FIRST) begin
            state_nxt = SWDT_FEED_HALF;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      SWDT_FEED_HALF: begin
        if (acc) begin
          state_nxt = SWDT_FEED_IDLE;
          if (feed_wr && wbyte == FEED_SECOND) begin
            ok_nxt = 1'b1;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = SWDT_FEED_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r  <= SWDT_FEED_IDLE;
      feed_ok  <= 1'b0;
      feed_err <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      feed_ok  <= ok_nxt;
      feed_err <= err_nxt;
    end
  end

  a_bad_second: assert property (
    @(posedge core_clk) disable iff (reset)
    (state_r == SWDT_FEED_HALF && acc && !(feed_wr && wbyte == FEED_SECOND)) |=> feed_err && !feed_ok)
    else $error("wrong second feed access not flagged");
  a_good_pair: assert property (
    @(posedge core_clk) disable iff (reset)
    (state_r == SWDT_FEED_HALF && acc && feed_wr && wbyte == FEED_SECOND) |=> feed_ok && !feed_err)
    else $error("valid feed pair not accepted");
endmodule : swdt_feed_seq
`default_nettype wire

/* hw/swdt_top.sv */
// What this block does
// - divide the clock by four to pace a 32-bit down-counter
// - counter drops by one on every prescaler pulse while above zero; a pulse at zero reloads it
// - reload values below FF are stored as FF
// - interval spans 256x4 to 2^32x4 clocks in steps of four
// - writing AA then 55 to the feed port reloads the counter
// - underflow with reset enabled resets the processor
// - timeout flag survives the watchdog reset; only software or an external reset clears it
// - software cannot disable a running watchdog
// - wrong or incomplete feed acts like an underflow
// - mode register reads back, writes only set control bits
// - reload register is read/write and resets to FF
// - live count reads back, resets to FF; feed port write-only
// - enable off idles; enable only interrupts; both also reset
// - after AA, any other mapped access triggers two clocks later
// - feed errors ignored until the first good feed after enable
// - interrupt flag set on timeout, cleared by any reset
`timescale 1ns/1ps
`default_nettype none
module swdt_top (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [swdt_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [swdt_pkg::DATA_W-1:0]  pwdata,
  output logic      [swdt_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq,
  output logic                              chip_reset
);
  import swdt_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic              en_r,      en_nxt;
  logic              rst_en_r,  rst_en_nxt;
  logic              tof_r,     tof_nxt;
  logic              int_r,     int_nxt;
  logic              armed_r,   armed_nxt;
  logic [31:0]       reload_r,  reload_nxt;
  logic [31:0]       count_r,   count_nxt;
  logic [EVT_W-1:0]  sts_r,     sts_nxt;
  logic [EVT_W-1:0]  ien_r,     ien_nxt;
  logic              err_d2_r;
  logic              chip_reset_nxt;
  logic              irq_nxt;
  logic [31:0]       prdata_nxt;
  logic              pready_nxt;
  logic              pslverr_nxt;

  logic              acc;
  logic              wr;
  logic              mapped;
  logic              run;
  logic              tick;
  logic              feed_ok;
  logic              feed_err;
  logic              err_hit;
  logic              underflow;
  logic              trig;
  logic [EVT_W-1:0]  evt;

  // ****************************************
  // bus decode
  // ****************************************
  assign acc    = psel && penable && pready;
  assign wr     = acc && pwrite;
  assign mapped = (paddr == OFS_MODE)    || (paddr == OFS_RELOAD)  ||
                  (paddr == OFS_FEED)    || (paddr == OFS_COUNT)   ||
                  (paddr == OFS_IRQ_STS) || (paddr == OFS_IRQ_EN)  ||
                  (paddr == OFS_IRQ_CLR);

  // ****************************************
  // prescaler and feed checker
  // ****************************************
  assign run = en_r && armed_r;

  swdt_prescale #(
    .DIV (PRESCALE_DIV)
  ) u_prescale (
    .core_clk (core_clk),
    .reset    (reset),
    .run      (run),
    .clr      (feed_ok),
    .tick     (tick)
  );

  swdt_feed_seq u_feed (
    .core_clk (core_clk),
    .reset    (reset),
    .acc      (acc && mapped),
    .feed_wr  (pwrite && paddr == OFS_FEED),
    .wbyte    (pwdata[7:0]),
    .feed_ok  (feed_ok),
    .feed_err (feed_err)
  );

  // ****************************************
  // trigger logic
  // ****************************************
  assign err_hit   = feed_err && en_r && armed_r;
  assign underflow = run && tick && !feed_ok && (count_r == '0);
  assign trig      = en_r && (underflow || err_d2_r);
  assign evt       = {err_d2_r && en_r, underflow};

  // ****************************************
  // watchdog control next state
  // ****************************************
  always_comb begin
    en_nxt         = en_r;
    rst_en_nxt     = rst_en_r;
    tof_nxt        = tof_r;
    int_nxt        = int_r;
    armed_nxt      = armed_r;
    reload_nxt     = reload_r;
    count_nxt      = count_r;
    chip_reset_nxt = 1'b0;
    if (wr && paddr == OFS_MODE) begin
      en_nxt     = en_r | pwdata[MODE_EN_BIT];
      rst_en_nxt = rst_en_r | pwdata[MODE_RST_BIT];
      if (!pwdata[MODE_TOF_BIT]) begin
        tof_nxt = 1'b0;
      end
    end
    if (wr && paddr == OFS_RELOAD) begin
      reload_nxt = (pwdata < RELOAD_MIN) ? RELOAD_MIN : pwdata;
    end
    if (feed_ok) begin
      count_nxt = reload_r;
      if (en_r) begin
        armed_nxt = 1'b1;
      end
    end else if (run && tick) begin
      count_nxt = (count_r == '0) ? reload_r : count_r - 32'h0000_0001;
    end
    if (trig) begin
      tof_nxt   = 1'b1;
      en_nxt    = 1'b0;
      rst_en_nxt = 1'b0;
      armed_nxt = 1'b0;
      if (rst_en_r) begin
        chip_reset_nxt = 1'b1;
        int_nxt        = 1'b0;
        count_nxt      = reload_r;
      end else begin
        int_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_r       <= 1'b0;
      rst_en_r   <= 1'b0;
      tof_r      <= 1'b0;
      int_r      <= 1'b0;
      armed_r    <= 1'b0;
      reload_r   <= RELOAD_RST;
      count_r    <= COUNT_RST;
      err_d2_r   <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      en_r       <= en_nxt;
      rst_en_r   <= rst_en_nxt;
      tof_r      <= tof_nxt;
      int_r      <= int_nxt;
      armed_r    <= armed_nxt;
      reload_r   <= reload_nxt;
      count_r    <= count_nxt;
      err_d2_r   <= err_hit;
      chip_reset <= chip_reset_nxt;
    end
  end

  // ****************************************
  // interrupt status, enable, output
  // ****************************************
  always_comb begin
    ien_nxt = ien_r;
    sts_nxt = sts_r;
    if (wr && paddr == OFS_IRQ_EN) begin
      ien_nxt = pwdata[EVT_W-1:0];
    end
    if (wr && paddr == OFS_IRQ_CLR) begin
      sts_nxt = sts_r & ~pwdata[EVT_W-1:0];
    end
    sts_nxt = sts_nxt | evt;
    irq_nxt = |(sts_nxt & ien_nxt);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sts_r <= '0;
      ien_r <= IRQ_EN_RST;
      irq   <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      ien_r <= ien_nxt;
      irq   <= irq_nxt;
    end
  end

  // ****************************************
  // bus answer, one wait state
  // ****************************************
  always_comb begin
    pready_nxt  = psel && penable && !pready;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    if (pready_nxt) begin
      pslverr_nxt = !mapped;
      if (!pwrite) begin
        case (paddr)
          OFS_MODE:    prdata_nxt = {28'h0000000, int_r, tof_r, rst_en_r, en_r};
          OFS_RELOAD:  prdata_nxt = reload_r;
          OFS_COUNT:   prdata_nxt = count_r;
          OFS_IRQ_STS: prdata_nxt = {30'h00000000, sts_r};
          OFS_IRQ_EN:  prdata_nxt = {30'h00000000, ien_r};
          default:     prdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_reload_floor: assert property (
    @(posedge core_clk) disable iff (reset) reload_r >= RELOAD_MIN)
    else $error("reload value below floor");
  a_feed_reload: assert property (
    @(posedge core_clk) disable iff (reset) (feed_ok && !trig) |=> count_r == $past(reload_r))
    else $error("feed did not reload");
  a_count_step: assert property (
    @(posedge core_clk) disable iff (reset)
    (run && tick && !feed_ok && !trig && count_r != '0) |=> count_r == $past(count_r) - 32'h0000_0001)
    else $error("counter did not step by one");
  a_enable_sticks: assert property (
    @(posedge core_clk) disable iff (reset) (en_r && !trig) |=> en_r)
    else $error("enable cleared without timeout");
  a_err_two_clk: assert property (
    @(posedge core_clk) disable iff (reset) err_hit |=> trig ##1 tof_r)
    else $error("feed error did not trigger in time");
  a_unarmed_quiet: assert property (
    @(posedge core_clk) disable iff (reset) (!armed_r && !err_d2_r) |-> !trig)
    else $error("trigger before first feed");
  a_reset_mode: assert property (
    @(posedge core_clk) disable iff (reset) (trig && rst_en_r) |=> chip_reset && tof_r && !en_r && !int_r)
    else $error("reset mode action wrong");
  a_int_mode: assert property (
    @(posedge core_clk) disable iff (reset) (trig && !rst_en_r) |=> !chip_reset && int_r && tof_r)
    else $error("interrupt mode action wrong");
  a_tof_kept: assert property (
    @(posedge core_clk) disable iff (reset) (tof_r && !(wr && paddr == OFS_MODE)) |=> tof_r)
    else $error("timeout flag lost");
  a_idle_stop: assert property (
    @(posedge core_clk) disable iff (reset) (!en_r && !feed_ok) |=> $stable(count_r))
    else $error("counter moved while disabled");
  a_rst_pulse: assert property (
    @(posedge core_clk) disable iff (reset) chip_reset |=> !chip_reset)
    else $error("chip reset longer than one clock");
  a_int_kept: assert property (
    @(posedge core_clk) disable iff (reset) (int_r && !(trig && rst_en_r)) |=> int_r)
    else $error("interrupt flag lost");
  a_rst_en_sticks: assert property (
    @(posedge core_clk) disable iff (reset) (rst_en_r && !trig) |=> rst_en_r)
    else $error("reset enable cleared without timeout");
  a_feed_phase: assert property (
    @(posedge core_clk) disable iff (reset) feed_ok |=> !tick [*3] ##1 (tick || !run))
    else $error("prescaler phase not cleared by feed");
  a_underflow_flag: assert property (
    @(posedge core_clk) disable iff (reset) underflow |=> sts_r[EVT_TIMEOUT] && tof_r)
    else $error("underflow not flagged");
  a_sts_sticky: assert property (
    @(posedge core_clk) disable iff (reset) !(wr && paddr == OFS_IRQ_CLR) |=> (sts_r & $past(sts_r)) == $past(sts_r))
    else $error("status bit lost without clear");
  a_irq_level: assert property (
    @(posedge core_clk) disable iff (reset) irq == |(sts_r & ien_r))
    else $error("interrupt output disagrees with status");
  a_ready_pulse: assert property (
    @(posedge core_clk) disable iff (reset) pready |=> !pready)
    else $error("ready held longer than one clock");
  a_err_unmapped: assert property (
    @(posedge core_clk) disable iff (reset) pready |-> pslverr == !mapped)
    else $error("error response disagrees with address map");
endmodule : swdt_top
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swdt_pkg::*;
  // ****************************************
  // stimulus and model state
  // ****************************************
  logic              core_clk;
  logic              reset;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              chip_reset;
  logic [31:0]       rd;
  logic              err;
  integer            fail_count;
  integer            total_checks;
  integer            seed;
  integer            n;
  integer            m_mode;
  integer            m_reload;
  integer            c1;
  integer            v;
  time               t0;

  swdt_top uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
                .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                .irq(irq), .chip_reset(chip_reset));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 20) fail_count++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (wr && a == OFS_RELOAD) m_reload = (d < 32'hFF) ? 32'hFF : d;
    if (wr && a == OFS_MODE) m_mode = (m_mode & 32'h3) | (d & 32'h3) | (m_mode & d & 32'h4) | (m_mode & 32'h8);
  endtask : apb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic feed();
    apb(1'b1, OFS_FEED, {24'h0, FEED_FIRST});
    apb(1'b1, OFS_FEED, {24'h0, FEED_SECOND});
  endtask : feed

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial begin
    #(5 * 20000);
    fail_count++;
    complete_run();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    fail_count = 0; total_checks = 0; seed = 95; m_mode = 0; m_reload = 32'hFF;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(OFS_MODE, m_mode);
    rd_chk(OFS_RELOAD, m_reload);
    rd_chk(OFS_COUNT, 32'hFF);
    rd_chk(OFS_IRQ_STS, 32'h0);
    rd_chk(OFS_IRQ_EN, 32'h0);
    end_test("reset values");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i == 0) v = 32'h10;
      if (i == 1) v = 32'hFE;
      apb(1'b1, OFS_RELOAD, v);
      rd_chk(OFS_RELOAD, m_reload);
    end
    apb(1'b1, OFS_RELOAD, 32'h0);
    rd_chk(OFS_RELOAD, 32'hFF);
    apb(1'b1, OFS_COUNT, 32'h1234);
    rd_chk(OFS_COUNT, 32'hFF);
    rd_chk(OFS_FEED, 32'h0);
    check(err, 1'b0);
    rd_chk(32'hE000_0020, 32'h0);
    check(err, 1'b1);
    end_test("register access");
    apb(1'b1, OFS_IRQ_EN, 32'h3);
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_FEED, 32'h12);
    repeat (4) @(posedge core_clk);
    rd_chk(OFS_IRQ_STS, 32'h0);
    check(irq, 1'b0);
    end_test("errors before arming");
    feed();
    t0 = $time;
    apb(1'b1, OFS_MODE, 32'h0);
    rd_chk(OFS_MODE, m_mode);
    apb(1'b0, OFS_COUNT, 32'h0);
    c1 = rd;
    check((c1 <= 32'hFF && c1 >= 32'hF0), 1'b1);
    repeat (40) @(posedge core_clk);
    apb(1'b0, OFS_COUNT, 32'h0);
    check((c1 - rd >= 9 && c1 - rd <= 12), 1'b1);
    feed();
    t0 = $time;
    while (irq !== 1'b1 && ($time - t0) < 5 * 1200) @(posedge core_clk);
    n = ($time - t0) / 5;
    check((n >= 1020 && n <= 1032), 1'b1);
    m_mode = 32'hC;
    rd_chk(OFS_MODE, m_mode);
    rd_chk(OFS_IRQ_STS, 32'h1);
    check(chip_reset, 1'b0);
    apb(1'b1, OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0);
    apb(1'b1, OFS_MODE, 32'h0);
    rd_chk(OFS_MODE, m_mode);
    end_test("interrupt timeout");
    apb(1'b1, OFS_MODE, 32'h3);
    feed();
    apb(1'b1, OFS_FEED, {24'h0, FEED_FIRST});
    apb(1'b0, OFS_MODE, 32'h0);
    check(rd, m_mode);
    n = 0;
    while (chip_reset !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    check((n >= 1 && n <= 4), 1'b1);
    m_mode = 32'h4;
    rd_chk(OFS_MODE, m_mode);
    rd_chk(OFS_IRQ_STS, 32'h2);
    check(irq, 1'b1);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0);
    end_test("reset trigger");
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    m_mode = 0;
    rd_chk(OFS_MODE, m_mode);
    rd_chk(OFS_COUNT, 32'hFF);
    end_test("external reset");
    complete_run();
  end
endmodule : tb
`default_nettype wire
